/* File: design/pds_control.sv */
// Serial programming, dividers, phase detector and lock detect of the synthesizer
`timescale 1ns/1ps
// Operation
// - MSB first, one bit per serial clock
// - Strobe rise copies word to one latch
// - Two low bits select destination latch
// - Reference divider ratio one to 16383
// - Main counter ratio three to 8191
// - Swallow counter accepts zero to 63
// - Feedback divide equals P times B plus A
// - Two bits set antibacklash pulse width
// - Three bits choose observation output source
// - Lock after three good cycles, precision 0
// - Lock after five good cycles, precision 1
// - Lock holds until error reaches unlock threshold or power-down
// - Analog lock high with low pulses
// - Counter reset bit holds all counters
// - Counters restart aligned after reset release
// - Chip enable low disables device immediately
// - Asynchronous power-down on latch load
// - Synchronous power-down waits for pump event
// - Power-down: counters load, pump three-state
// - Startup word loads settings, pulses reset
// - Pump disable bit three-states pump output
module pds_control (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ser_clk,
    input wire logic i_ser_data,
    input wire logic i_load_strobe,
    input wire logic i_chip_en,
    input wire logic i_ref_in,
    input wire logic i_rf_in,
    output logic o_pump_up,
    output logic o_pump_dn,
    output logic o_pump_oe_n,
    output logic o_pump_gain_sel,
    output logic o_obs,
    output logic o_obs_oe_n,
    output logic o_powered_down
);
    import pds_pkg::*;

    // ----------------------------------------
    // Link domain shift register
    // ----------------------------------------
    logic [23:0] shift_reg;

    // Host sends MSB first, so new bits enter at the bottom
    always_ff @(posedge i_ser_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_reg <= LATCH_RST;
        end else begin
            shift_reg <= {shift_reg[22:0], i_ser_data};
        end
    end
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Bits: 0 strobe, 1 chip enable, 2 reference, 3 rf, 4 serial out
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] prev_reg;
    wire [4:0] async_in = {shift_reg[23], i_rf_in, i_ref_in, i_chip_en, i_load_strobe};

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            prev_reg <= 5'h00;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    wire strobe_rise = sync2_reg[0] & ~prev_reg[0];
    wire ce_s = sync2_reg[1];
    wire ref_rise = sync2_reg[2] & ~prev_reg[2];
    wire rf_rise = sync2_reg[3] & ~prev_reg[3];
    wire sdo_s = sync2_reg[4];
    // ----------------------------------------
    // Latch bank
    // ----------------------------------------
    // The shift word is quiet by the time the synced strobe edge arrives,
    // so it is sampled here without its own crossing
    wire [23:0] word = shift_reg;
    wire [1:0] sel = word[1:0];
    wire ld_ref = strobe_rise && (sel == SEL_REF);
    wire ld_fb = strobe_rise && (sel == SEL_FB);
    wire ld_init = strobe_rise && (sel == SEL_INIT);
    wire ld_func = strobe_rise && ((sel == SEL_FUNC) || ld_init);

    logic [23:0] ref_word_reg;
    logic [23:0] fb_word_reg;
    logic [23:0] func_word_reg;

    // Only the main reset clears the latches; chip enable leaves them alone
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ref_word_reg <= LATCH_RST;
            fb_word_reg <= LATCH_RST;
            func_word_reg <= LATCH_RST;
        end else begin
            if (ld_ref) ref_word_reg <= word;
            if (ld_fb) fb_word_reg <= word;
            if (ld_func) func_word_reg <= word;
        end
    end

    pds_ref_type rw;
    pds_fb_type fw;
    pds_func_type cw;
    pds_func_type nw;
    assign rw = ref_word_reg;
    assign fw = fb_word_reg;
    assign cw = func_word_reg;
    assign nw = word;
    // ----------------------------------------
    // Power-down and internal reset pulse
    // ----------------------------------------
    logic pd_reg;
    logic pd_next;
    logic pend_reg;
    logic pend_next;
    logic init_pulse_reg;
    logic armed_reg;
    logic cp_event;

    wire pd_clear_ld = ld_func && !nw.powerdown_request;
    wire pd_async_ld = ld_func && nw.powerdown_request && !nw.powerdown_sync_sel;
    wire pd_sync_ld = ld_func && nw.powerdown_request && nw.powerdown_sync_sel;
    wire powered_off = pd_reg || !ce_s;
    // Any power-down, counter reset or internal pulse parks the counters
    wire hold = powered_off || cw.counter_reset_bit || init_pulse_reg;
    wire sync_fire = pend_reg && cp_event && !pd_clear_ld;

    // Power-down state; a fresh clear in the same cycle wins
    always_comb begin
        pd_next = pd_reg;
        pend_next = pend_reg;
        if (pd_clear_ld) begin
            pd_next = 1'b0;
            pend_next = 1'b0;
        end else if (pd_async_ld) begin
            pd_next = 1'b1;
            pend_next = 1'b0;
        end else if (pd_sync_ld) begin
            pend_next = 1'b1;
        end else if (sync_fire) begin
            pd_next = 1'b1;
            pend_next = 1'b0;
        end
    end

    // Startup word pulses, and arms one more pulse for the next feedback load
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pd_reg <= 1'b0;
            pend_reg <= 1'b0;
            init_pulse_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            pd_reg <= pd_next;
            pend_reg <= pend_next;
            init_pulse_reg <= ld_init || (ld_fb && armed_reg);
            armed_reg <= ld_init ? 1'b1 : (ld_fb ? 1'b0 : armed_reg);
        end
    end

    // ----------------------------------------
    // Reference divider and feedback counters
    // ----------------------------------------
    logic [13:0] ref_cnt_reg;
    logic [6:0] pre_cnt_reg;
    logic [12:0] b_cnt_reg;
    logic [5:0] a_left_reg;
    logic ref_tick_reg;
    logic n_tick_reg;

    // Ratios under the minimum (R of zero, B under three) clamp to the least legal ratio
    wire [13:0] r_eff = (rw.ref_divide_value < REF_MIN) ? REF_MIN : rw.ref_divide_value;
    wire [12:0] b_eff = (fw.main_count < MAIN_MIN) ? MAIN_MIN : fw.main_count;
    wire [6:0] p_mod = PRESCALE_BASE << cw.prescale_select;
    wire [6:0] cur_mod = (a_left_reg != 6'h00) ? 7'(p_mod + 7'h01) : p_mod;
    wire ref_hit = ref_rise && (ref_cnt_reg == 14'(r_eff - 14'h0001));
    wire pre_tick = rf_rise && (pre_cnt_reg == 7'(cur_mod - 7'h01));
    wire b_hit = pre_tick && (b_cnt_reg == 13'(b_eff - 13'h0001));

    // Both chains leave the load state together, which keeps them aligned
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ref_cnt_reg <= 14'h0000;
            ref_tick_reg <= 1'b0;
        end else if (hold) begin
            ref_cnt_reg <= 14'h0000;
            ref_tick_reg <= 1'b0;
        end else begin
            ref_cnt_reg <= ref_hit ? 14'h0000 : (ref_rise ? 14'(ref_cnt_reg + 14'h0001)
                : ref_cnt_reg);
            ref_tick_reg <= ref_hit;
        end
    end

    // Dual modulus: A prescaler cycles of P+1, then the rest at P
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pre_cnt_reg <= 7'h00;
            b_cnt_reg <= 13'h0000;
            a_left_reg <= 6'h00;
            n_tick_reg <= 1'b0;
        end else if (hold) begin
            pre_cnt_reg <= 7'h00;
            b_cnt_reg <= 13'h0000;
            a_left_reg <= fw.swallow_count;
            n_tick_reg <= 1'b0;
        end else begin
            n_tick_reg <= b_hit;
            if (rf_rise) begin
                pre_cnt_reg <= pre_tick ? 7'h00 : 7'(pre_cnt_reg + 7'h01);
            end
            if (b_hit) begin
                b_cnt_reg <= 13'h0000;
                a_left_reg <= fw.swallow_count;
            end else if (pre_tick) begin
                b_cnt_reg <= 13'(b_cnt_reg + 13'h0001);
                a_left_reg <= (a_left_reg != 6'h00) ? 6'(a_left_reg - 6'h01) : 6'h00;
            end
        end
    end
    // ----------------------------------------
    // Phase detector with antibacklash delay
    // ----------------------------------------
    logic up_reg;
    logic dn_reg;
    logic [2:0] ab_cnt_reg;
    logic [7:0] err_reg;

    wire both = up_reg && dn_reg;
    wire [2:0] abw_cyc = 3'({1'b0, rw.antibacklash_width} + ABW_BASE_CYC);
    wire pfd_end = both && (ab_cnt_reg == abw_cyc);
    assign cp_event = ((ref_tick_reg || n_tick_reg) && !up_reg && !dn_reg) || init_pulse_reg;

    // Error counts cycles with exactly one side active; saturates
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
            ab_cnt_reg <= 3'h0;
            err_reg <= 8'h00;
        end else if (hold || pfd_end) begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
            ab_cnt_reg <= 3'h0;
            err_reg <= 8'h00;
        end else begin
            up_reg <= up_reg || ref_tick_reg;
            dn_reg <= dn_reg || n_tick_reg;
            ab_cnt_reg <= both ? 3'(ab_cnt_reg + 3'h1) : 3'h0;
            if ((up_reg ^ dn_reg) && (err_reg != 8'hff)) begin
                err_reg <= 8'(err_reg + 8'h01);
            end
        end
    end

    // ----------------------------------------
    // Digital lock detect
    // ----------------------------------------
    logic [2:0] good_reg;
    logic lock_reg;

    wire [2:0] need = rw.lock_precision_sel ? LOCK_CNT_SLOW : LOCK_CNT_FAST;
    wire err_small = err_reg < LOCK_ERR_CYC;
    wire err_big = err_reg >= UNLOCK_ERR_CYC;
    wire [2:0] good_inc = (good_reg == 3'h7) ? good_reg : 3'(good_reg + 3'h1);

    // Errors between the two thresholds restart the count but keep lock
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            good_reg <= 3'h0;
            lock_reg <= 1'b0;
        end else if (powered_off) begin
            good_reg <= 3'h0;
            lock_reg <= 1'b0;
        end else if (pfd_end) begin
            good_reg <= err_small ? good_inc : 3'h0;
            if (err_big) begin
                lock_reg <= 1'b0;
            end else if (err_small && (good_inc >= need)) begin
                lock_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic obs_val;
    logic obs_oe_n_val;
    wire alock_low = up_reg || dn_reg;

    // Observation source select
    always_comb begin
        obs_val = 1'b0;
        obs_oe_n_val = 1'b0;
        case (cw.observe_sel)
            OBS_TRI: obs_oe_n_val = 1'b1;
            OBS_DLOCK: obs_val = lock_reg;
            OBS_NDIV: obs_val = n_tick_reg;
            OBS_HIGH: obs_val = 1'b1;
            OBS_RDIV: obs_val = ref_tick_reg;
            OBS_ALOCK: obs_oe_n_val = !alock_low;
            OBS_SDO: obs_val = sdo_s;
            default: obs_val = 1'b0;
        endcase
    end

    // Registered pins; polarity swaps the pump directions
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pump_up <= 1'b0;
            o_pump_dn <= 1'b0;
            o_pump_oe_n <= 1'b1;
            o_pump_gain_sel <= 1'b0;
            o_obs <= 1'b0;
            o_obs_oe_n <= 1'b1;
            o_powered_down <= 1'b0;
        end else begin
            o_pump_up <= cw.pd_polarity ? up_reg : dn_reg;
            o_pump_dn <= cw.pd_polarity ? dn_reg : up_reg;
            o_pump_oe_n <= hold || cw.pump_disable_bit;
            o_pump_gain_sel <= fw.pump_gain_sel;
            o_obs <= obs_val;
            o_obs_oe_n <= obs_oe_n_val;
            o_powered_down <= powered_off;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    property p_route_ref;
        ld_ref |=> (ref_word_reg == $past(word)) && $stable(fb_word_reg);
    endproperty
    a_route_ref: assert property (p_route_ref) else $error("ref word not routed");
    property p_one_latch;
        ld_fb |=> $stable(ref_word_reg) && $stable(func_word_reg);
    endproperty
    a_one_latch: assert property (p_one_latch) else $error("extra latch changed");
    property p_hold;
        cw.counter_reset_bit |=> (ref_cnt_reg == 14'h0000) && (b_cnt_reg == 13'h0000);
    endproperty
    a_hold: assert property (p_hold) else $error("counters not held");
    property p_pd_async;
        pd_async_ld |=> pd_reg ##1 o_powered_down && o_pump_oe_n;
    endproperty
    a_pd_async: assert property (p_pd_async) else $error("async power-down late");
    property p_pd_sync;
        pend_reg && !cp_event && !pd_clear_ld && !pd_async_ld |=> !$rose(pd_reg);
    endproperty
    a_pd_sync: assert property (p_pd_sync) else $error("sync power-down early");
    property p_ce_off;
        !ce_s |=> o_pump_oe_n && o_powered_down && !lock_reg;
    endproperty
    a_ce_off: assert property (p_ce_off) else $error("chip enable ignored");
    property p_unlock;
        pfd_end && err_big && !powered_off |=> !lock_reg && (good_reg == 3'h0);
    endproperty
    a_unlock: assert property (p_unlock) else $error("lock kept on big error");
    property p_lock_fast;
        pfd_end && err_small && !rw.lock_precision_sel && (good_reg == 3'h2) && !powered_off
            |=> lock_reg;
    endproperty
    a_lock_fast: assert property (p_lock_fast) else $error("lock missed at three");
    property p_lock_slow;
        $rose(lock_reg) && $past(rw.lock_precision_sel) |-> $past(good_reg) >= 3'h4;
    endproperty
    a_lock_slow: assert property (p_lock_slow) else $error("lock before five");
    property p_init_pulse;
        ld_init |=> init_pulse_reg ##1 (pre_cnt_reg == 7'h00) && (ref_cnt_reg == 14'h0000);
    endproperty
    a_init_pulse: assert property (p_init_pulse) else $error("startup pulse missing");
    property p_pump_dis;
        cw.pump_disable_bit |=> o_pump_oe_n;
    endproperty
    a_pump_dis: assert property (p_pump_dis) else $error("pump not three-state");
    c_lock: cover property ($rose(lock_reg));
    c_pd_sync: cover property (sync_fire ##1 pd_reg);
    c_n_tick: cover property (n_tick_reg ##[1:200] ref_tick_reg);
    c_rearm: cover property (ld_init ##[1:1000] ld_fb ##1 init_pulse_reg);
endmodule

/* File: design/pds_pkg.sv */
// Shared constants and word layouts for the synthesizer serial control block
package pds_pkg;
    // Latch select codes in the two low bits of a word
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_FB = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;
    localparam int WORD_W = 24;
    localparam logic [23:0] LATCH_RST = 24'h000000;
    // Observation output selections
    localparam logic [2:0] OBS_TRI = 3'h0;
    localparam logic [2:0] OBS_DLOCK = 3'h1;
    localparam logic [2:0] OBS_NDIV = 3'h2;
    localparam logic [2:0] OBS_HIGH = 3'h3;
    localparam logic [2:0] OBS_RDIV = 3'h4;
    localparam logic [2:0] OBS_ALOCK = 3'h5;
    localparam logic [2:0] OBS_SDO = 3'h6;
    // Counter limits
    localparam logic [12:0] MAIN_MIN = 13'h0003;
    localparam logic [13:0] REF_MIN = 14'h0001;
    localparam logic [6:0] PRESCALE_BASE = 7'h08;
    localparam logic [2:0] LOCK_CNT_FAST = 3'h3;
    localparam logic [2:0] LOCK_CNT_SLOW = 3'h5;
    localparam logic [2:0] ABW_BASE_CYC = 3'h1;
    // Timing: phase error thresholds against the system clock period
    localparam int CLK_PERIOD_NS = 50;
    localparam int LOCK_ERR_NS = 15;
    localparam int UNLOCK_ERR_NS = 25;
    localparam int LOCK_RAW = LOCK_ERR_NS / CLK_PERIOD_NS;
    localparam int UNLOCK_RAW = (UNLOCK_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] LOCK_ERR_CYC = 8'((LOCK_RAW < 1) ? 1 : LOCK_RAW);
    localparam logic [7:0] UNLOCK_ERR_CYC = 8'((UNLOCK_RAW < 1) ? 1 : UNLOCK_RAW);
    // Reference divider word
    typedef struct packed {
        logic x23;
        logic [1:0] rsvd;
        logic lock_precision_sel;
        logic [1:0] test_mode_bits;
        logic [1:0] antibacklash_width;
        logic [13:0] ref_divide_value;
        logic [1:0] latch_select;
    } pds_ref_type;
    // Feedback counter word
    typedef struct packed {
        logic [1:0] rsvd;
        logic pump_gain_sel;
        logic [12:0] main_count;
        logic [5:0] swallow_count;
        logic [1:0] latch_select;
    } pds_fb_type;
    // Function settings word, shared by the startup word
    typedef struct packed {
        logic [1:0] prescale_select;
        logic powerdown_sync_sel;
        logic [5:0] current_settings;
        logic [3:0] timer_bits;
        logic [1:0] fastlock_bits;
        logic pump_disable_bit;
        logic pd_polarity;
        logic [2:0] observe_sel;
        logic powerdown_request;
        logic counter_reset_bit;
        logic [1:0] latch_select;
    } pds_func_type;
endpackage

/* File: test/pds_host_model.sv */
// Host side of the three-wire serial programming link
`timescale 1ns/1ps
module pds_host_model (
    input wire logic i_clk_sys,
    output logic o_ser_clk,
    output logic o_ser_data,
    output logic o_load_strobe
);
    // -------------------------------------------------------------
    // Link clock only runs inside frames
    // -------------------------------------------------------------
    initial begin
        o_ser_clk = 1'b0;
        o_ser_data = 1'b0;
        o_load_strobe = 1'b0;
    end
    // One frame: 24 bits at a 32 ns link period, then the strobe
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            o_ser_data = w[i];
            #16 o_ser_clk = 1'b1;
            #16 o_ser_clk = 1'b0;
        end
        o_ser_data = ~w[0]; // Released line must not echo the last bit
        #16 o_load_strobe = 1'b1;
        // Wide strobe and quiet gap, since the word crosses without a handshake
        repeat (4) @(posedge i_clk_sys);
        #1 o_load_strobe = 1'b0;
        repeat (4) @(posedge i_clk_sys);
    endtask
endmodule

/* File: test/pll_divider_serial_control_test.sv */
// Self-checking bench for the synthesizer serial control block
`timescale 1ns/1ps
module pll_divider_serial_control_test;
    import pds_pkg::*;
    logic clk, rst, ser_clk, ser_data, strobe, ref_in, rf_in, chip_en;
    logic pump_up, pump_dn, pump_oe_n, gain, obs, obs_oe_n, pwr_dn;
    logic [1:0] ph = 2'h0;
    logic [12:0] b;
    logic [5:0] a;
    logic [13:0] r;
    int failures, n_checks, n, rises = 0, cyc = 0;
    int lat[4];

    pds_host_model host (.i_clk_sys(clk), .o_ser_clk(ser_clk), .o_ser_data(ser_data),
        .o_load_strobe(strobe));
    pds_control DUT (.i_clk_sys(clk), .i_rst(rst), .i_ser_clk(ser_clk),
        .i_ser_data(ser_data), .i_load_strobe(strobe), .i_chip_en(chip_en),
        .i_ref_in(ref_in), .i_rf_in(rf_in), .o_pump_up(pump_up), .o_pump_dn(pump_dn),
        .o_pump_oe_n(pump_oe_n), .o_pump_gain_sel(gain), .o_obs(obs),
        .o_obs_oe_n(obs_oe_n), .o_powered_down(pwr_dn));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // -------------------------------------------------------------
    // Slow reference and RF inputs: two cycles high, two low
    // -------------------------------------------------------------
    always @(posedge clk) begin
        ph <= ph + 2'h1;
        ref_in <= ph[1];
        rf_in <= ph[1];
        if (ph == 2'h2) rises <= rises + 1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            $display("[FAIL] timeout expected finish seen hang");
            wrap_up();
        end
    end

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Send a word and update the latch model
    task automatic load(input logic [23:0] w);
        host.send(w);
        lat[w[1:0]] = int'(w);
        if (w[1:0] == SEL_INIT) lat[SEL_FUNC] = int'(w);
        repeat (8) @(posedge clk);
    endtask
    // Input rises between two observation pulses, -1 if none seen
    task automatic gap(output int cnt);
        int base;
        int seen;
        logic prev;
        base = 0;
        seen = 0;
        cnt = -1;
        prev = obs;
        for (int k = 0; k < 3000 && seen < 2; k++) begin
            @(posedge clk);
            #1;
            if (obs === 1'b1 && prev === 1'b0) begin
                seen++;
                cnt = rises - base;
                base = rises;
            end
            prev = obs;
        end
    endtask
    function automatic logic [23:0] fn_w(input logic [1:0] sel, input logic [2:0] m,
        input logic [1:0] ps, input logic pd1, input logic pd2, input logic f1,
        input logic f3);
        pds_func_type f;
        f = '0;
        f.latch_select = sel;
        f.observe_sel = m;
        f.prescale_select = ps;
        f.powerdown_request = pd1;
        f.powerdown_sync_sel = pd2;
        f.counter_reset_bit = f1;
        f.pump_disable_bit = f3;
        f.pd_polarity = 1'b1;
        return f;
    endfunction
    function automatic logic [23:0] fb_w(input logic g);
        pds_fb_type f;
        f = '0;
        f.latch_select = SEL_FB;
        f.pump_gain_sel = g;
        f.main_count = b;
        f.swallow_count = a;
        return f;
    endfunction
    function automatic logic [23:0] rf_w(input logic [13:0] rv);
        pds_ref_type f;
        f = '0;
        f.latch_select = SEL_REF;
        f.ref_divide_value = rv;
        return f;
    endfunction

    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        void'($urandom(32'h65c154ea));
        rst = 1'b1;
        chip_en = 1'b1;
        lat = '{default: 0};
        b = MAIN_MIN;
        // Swallow count may not exceed the main count, or the split P+1/P fails
        a = 6'($urandom_range(b));
        r = 14'($urandom_range(5, 2));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        check("powered_down", 16'h0, 16'(pwr_dn));
        check("pump_oe_n", 16'h0, 16'(pump_oe_n));
        check("obs_oe_n", 16'h1, 16'(obs_oe_n));
        load(fn_w(SEL_INIT, OBS_HIGH, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        check("obs_init", 16'h1, 16'(obs));
        load(fb_w(1'b1));
        check("gain", 16'(lat[1][21]), 16'(gain));
        load(rf_w(r));
        check("gain_kept", 16'(lat[1][21]), 16'(gain));
        // Fixed levels on the observation pin
        // Third pass shows the top shift bit, the first bit sent of the word
        for (int m = 0; m < 3; m++) begin
            load(fn_w(SEL_FUNC, (m == 0) ? OBS_HIGH : ((m == 1) ? 3'h7 : OBS_SDO),
                (m == 2) ? 2'h2 : 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
            check("obs_level", (m == 1) ? 16'h0 : 16'h1, 16'(obs));
            check("obs_drive", 16'h0, 16'(obs_oe_n));
        end
        // Slow RF keeps the prescaler output far inside its limit
        for (int p = 0; p < 4; p++) begin
            load(fn_w(SEL_FUNC, OBS_NDIV, 2'(p), 1'b0, 1'b0, 1'b0, 1'b0));
            gap(n);
            check("n_div", 16'((8 << p) * b + a), 16'(n));
        end
        load(fn_w(SEL_FUNC, OBS_RDIV, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        for (int k = 0; k < 2; k++) begin
            load(rf_w((k == 0) ? REF_MIN : r));
            gap(n);
            check("r_div", (k == 0) ? 16'(REF_MIN) : 16'(r), 16'(n));
        end
        // Reference ratio equal to the feedback ratio, so the aligned restart locks
        load(rf_w(14'(8 * b + a)));
        // Counter reset holds the feedback path, release restarts it
        load(fn_w(SEL_FUNC, OBS_NDIV, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0));
        check("hold_pump_oe_n", 16'h1, 16'(pump_oe_n));
        gap(n);
        check("held_ticks", 16'hffff, 16'(n));
        load(fn_w(SEL_FUNC, OBS_NDIV, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        gap(n);
        check("n_restart", 16'(8 * b + a), 16'(n));
        // Matched dividers on one input phase: digital lock, then narrow analog pulses
        load(fn_w(SEL_FUNC, OBS_DLOCK, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        repeat (1000) @(posedge clk);
        check("dig_lock", 16'h1, 16'(obs));
        load(fn_w(SEL_FUNC, OBS_ALOCK, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        n = 0;
        for (int k = 0; k < 400; k++) begin
            @(posedge clk);
            n += (obs_oe_n === 1'b0) ? 1 : 0;
        end
        check("alock_obs", 16'h0, 16'(obs));
        check("alock_narrow", 16'h1, 16'(n > 0 && n < 40));
        load(fn_w(SEL_FUNC, OBS_NDIV, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1));
        check("pump_disable", 16'h1, 16'(pump_oe_n));
        load(fn_w(SEL_FUNC, OBS_NDIV, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0));
        check("async_pd", 16'h1, 16'(pwr_dn));
        check("pd_pump_oe_n", 16'h1, 16'(pump_oe_n));
        load(fn_w(SEL_FUNC, OBS_NDIV, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        check("pd_clear", 16'h0, 16'(pwr_dn));
        // Synchronous entry waits for a pump event, bounded by a few PD cycles
        load(fn_w(SEL_FUNC, OBS_NDIV, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0));
        for (int k = 0; k < 200 && pwr_dn !== 1'b1; k++) @(posedge clk);
        check("sync_pd", 16'h1, 16'(pwr_dn));
        load(fn_w(SEL_FUNC, OBS_HIGH, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        // Chip enable low, program while off, latches survive the cycle
        @(posedge clk);
        chip_en <= 1'b0;
        repeat (4) @(posedge clk);
        check("ce_off", 16'h1, 16'(pwr_dn));
        check("ce_pump_oe_n", 16'h1, 16'(pump_oe_n));
        load(fb_w(1'b0));
        chip_en <= 1'b1;
        repeat (6) @(posedge clk);
        check("ce_on", 16'h0, 16'(pwr_dn));
        check("gain_off_load", 16'(lat[1][21]), 16'(gain));
        check("obs_persist", 16'h1, 16'(obs));
        wrap_up();
    end
endmodule
